// ===== cathode_supply_defs.svh
/*
  Register offsets, field positions, reset values and timing figures for
  the cathode-supply converter control block.
  Assumes inclusion by bare name from the package and design file.
*/
`ifndef CATHODE_SUPPLY_DEFS_SVH
`define CATHODE_SUPPLY_DEFS_SVH

`define OFS_MODE_SENSE 8'h0E
`define OFS_PUMP_CTL 8'h0F
`define OFS_MAX_PIX 8'h10
`define OFS_MANUAL 8'h11
`define OFS_REF_CUR 8'h12
`define OFS_DIMMING 8'h13

`define MODE_SENSE_MASK 8'h0F
`define DIMMING_MASK 8'h7F

`define RST_MODE_SENSE 8'h04
`define RST_PUMP_CTL 8'h3D
`define RST_MAX_PIX 8'h0D
`define RST_MANUAL 8'h51
`define RST_REF_CUR 8'h00
`define RST_DIMMING 8'h01

`define SENSE_LSB 2
`define MODE_LSB 0
`define BYPASS_BIT 7
`define DUTY_LSB 4
`define FREQ_LSB 2
`define SS_LSB 0
`define COARSE_LSB 5

`define CLK_HZ 50000000
`define SS_BASE_MS 2

`endif

// ===== cathode_supply_pkg.sv
/*
  Types shared by the cathode-supply converter control block.
  Assumes cathode_supply_defs.svh is on the include path.
*/
`include "cathode_supply_defs.svh"
package cathode_supply_pkg;

  typedef enum logic [1:0] {
    fixed_current_mode = 2'b00,
    clamped_current_mode = 2'b01,
    manual_voltage_mode = 2'b10,
    undefined_mode = 2'b11
  } converter_mode_t;

  typedef enum logic [1:0] {
    st_off = 2'b00,
    st_soft_start = 2'b01,
    st_running = 2'b10,
    st_tripped = 2'b11
  } pump_state_t;

  // Settings handed to the analog regulation loop
  typedef struct packed {
    logic fixed_voltage;
    logic current_loop;
    logic clamp_enable;
    logic [7:0] voltage_target;
    logic [7:0] max_pixel_voltage;
    logic [8:0] reference_factor;
    logic [6:0] dimming;
  } regulator_cfg_t;

endpackage

// ===== cathode_supply_regulator_ctl.sv
/*
  Cathode-supply charge-pump converter control: an AHB-Lite register
  slave, the pump clock generator with duty and frequency select, soft
  start, overcurrent shutdown, and the settings for the analog loop.
  Assumes mclk at 50 MHz, synchronous active-high reset, and that
  overcurrent_detect and converter_enable are synchronous to mclk.
*/
// Implementation choice: the AHB-Lite interface to the registers.
`include "cathode_supply_defs.svh"
module cathode_supply_regulator_ctl #(
  parameter int SS_UNIT_CYCLES = (`CLK_HZ / 1000) * `SS_BASE_MS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic converter_enable,
  input wire logic overcurrent_detect,
  output logic pump_drive_output,
  output logic soft_start_active,
  output logic overcurrent_trip,
  output cathode_supply_pkg::regulator_cfg_t regulator_cfg
);

  // A zero unit would wrap the end count to all ones and stretch soft start to 2^32 cycles
  if (SS_UNIT_CYCLES < 1) begin : g_bad_unit
    $error("SS_UNIT_CYCLES must be at least one");
  end

  // ==========================================================
  // Register file
  // ==========================================================
  logic [7:0] cathode_mode_sense;
  logic [7:0] cathode_pump_control;
  logic [7:0] max_pixel_voltage;
  logic [7:0] cathode_manual_level;
  logic [7:0] array_reference_current;
  logic [7:0] luminance_dimming;

  logic wr_pending;
  logic [7:0] wr_addr;

  wire addr_phase = hsel && hready && htrans[1];
  wire [7:0] wdata = hwdata[7:0];
  wire wr_mode = wr_pending && (wr_addr == `OFS_MODE_SENSE);
  wire wr_pump = wr_pending && (wr_addr == `OFS_PUMP_CTL);
  wire wr_vmax = wr_pending && (wr_addr == `OFS_MAX_PIX);
  wire wr_man = wr_pending && (wr_addr == `OFS_MANUAL);
  wire wr_ref = wr_pending && (wr_addr == `OFS_REF_CUR);
  wire wr_dim = wr_pending && (wr_addr == `OFS_DIMMING);

  function automatic logic [7:0] read_mux(input logic [7:0] a,
      input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r2,
      input logic [7:0] r3, input logic [7:0] r4, input logic [7:0] r5);
    case (a)
      `OFS_MODE_SENSE: read_mux = r0;
      `OFS_PUMP_CTL: read_mux = r1;
      `OFS_MAX_PIX: read_mux = r2;
      `OFS_MANUAL: read_mux = r3;
      `OFS_REF_CUR: read_mux = r4;
      `OFS_DIMMING: read_mux = r5;
      default: read_mux = 8'h00;
    endcase
  endfunction

  wire [7:0] next_rdata = read_mux({haddr[7:2], 2'b00} >> 2,
    cathode_mode_sense, cathode_pump_control, max_pixel_voltage,
    cathode_manual_level, array_reference_current, luminance_dimming);

  // Zero wait states; write data lands one cycle after the address phase
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      wr_pending <= addr_phase && hwrite;
      wr_addr <= {2'b00, haddr[7:2]};
      if (addr_phase && !hwrite) begin
        hrdata <= {24'h00_0000, next_rdata};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cathode_mode_sense <= `RST_MODE_SENSE;
      cathode_pump_control <= `RST_PUMP_CTL;
      max_pixel_voltage <= `RST_MAX_PIX;
      cathode_manual_level <= `RST_MANUAL;
      array_reference_current <= `RST_REF_CUR;
      luminance_dimming <= `RST_DIMMING;
    end else if (clk_en) begin
      if (wr_mode) cathode_mode_sense <= wdata & `MODE_SENSE_MASK;
      if (wr_pump) cathode_pump_control <= wdata;
      if (wr_vmax) max_pixel_voltage <= wdata;
      if (wr_man) cathode_manual_level <= wdata;
      if (wr_ref) array_reference_current <= wdata;
      if (wr_dim) luminance_dimming <= wdata & `DIMMING_MASK;
    end
  end

  // ==========================================================
  // Field decode
  // ==========================================================
  wire [1:0] sense_code = cathode_mode_sense[`SENSE_LSB +: 2];
  wire sense_on = (sense_code[0] == 1'b1);
  wire [1:0] mode_code = cathode_mode_sense[`MODE_LSB +: 2];
  wire ss_bypass = cathode_pump_control[`BYPASS_BIT];
  wire [2:0] duty_code = cathode_pump_control[`DUTY_LSB +: 3];
  wire [1:0] freq_code = cathode_pump_control[`FREQ_LSB +: 2];
  wire [1:0] ss_code = cathode_pump_control[`SS_LSB +: 2];
  wire [2:0] coarse = array_reference_current[`COARSE_LSB +: 3];
  wire [4:0] fine = array_reference_current[4:0];

  cathode_supply_pkg::converter_mode_t mode;
  // Undefined code falls back to the reset mode
  assign mode = (mode_code == 2'b11) ? cathode_supply_pkg::fixed_current_mode
    : cathode_supply_pkg::converter_mode_t'(mode_code);

  // Coarse in half units: 0, 1, 3, 5 ... 13; factor in 1/32 units
  wire [3:0] coarse_halves = (coarse == 3'h0) ? 4'h0
    : 4'({coarse, 1'b0} - 4'h1);
  wire [8:0] next_factor = 9'({coarse_halves, 4'h0}) + 9'(fine);

  // ==========================================================
  // Pump clock: period and high time in mclk cycles
  // ==========================================================
  function automatic logic [8:0] period_of(input logic [1:0] f);
    case (f)
      2'h0: period_of = 9'h190; // 125 kHz
      2'h1: period_of = 9'h0C8; // 250 kHz
      2'h2: period_of = 9'h064; // 500 kHz
      default: period_of = 9'h03E; // 800 kHz, nearest whole count
    endcase
  endfunction

  // High eighths for duty codes 0..6; 7 is unusable, held at 1:1
  wire [3:0] high_eighths = (duty_code == 3'h7) ? 4'h4
    : 4'({1'b0, duty_code} + 4'h1);
  wire [8:0] period = period_of(freq_code);
  wire [12:0] high_prod = 13'(period) * 13'(high_eighths);
  wire [8:0] high_time = high_prod[11:3];

  // ==========================================================
  // Start-up sequencer
  // ==========================================================
  cathode_supply_pkg::pump_state_t state, next_state;
  logic [8:0] phase;
  logic [31:0] ss_count;
  wire [31:0] ss_limit = SS_UNIT_CYCLES << ss_code;
  wire oc_event = sense_on && overcurrent_detect;

  always_comb begin
    next_state = state;
    case (state)
      cathode_supply_pkg::st_off: begin
        if (converter_enable) begin
          next_state = ss_bypass ? cathode_supply_pkg::st_running
            : cathode_supply_pkg::st_soft_start;
        end
      end
      cathode_supply_pkg::st_soft_start: begin
        if (ss_count >= ss_limit - 32'h1) begin
          next_state = cathode_supply_pkg::st_running;
        end
      end
      cathode_supply_pkg::st_running: begin
      end
      cathode_supply_pkg::st_tripped: begin
      end
      default: next_state = cathode_supply_pkg::st_off;
    endcase
    if (!converter_enable) begin
      next_state = cathode_supply_pkg::st_off;
    end else if (oc_event) begin
      next_state = cathode_supply_pkg::st_tripped;
    end
  end

  wire pumping = (next_state == cathode_supply_pkg::st_soft_start)
    || (next_state == cathode_supply_pkg::st_running);
  wire phase_wrap = (phase >= period - 9'h1);
  // Trip latches until the converter is disabled, protecting the pump parts
  wire next_drive = pumping && (phase < high_time);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= cathode_supply_pkg::st_off;
      phase <= 9'h000;
      ss_count <= 32'h0000_0000;
      pump_drive_output <= 1'b0;
      soft_start_active <= 1'b0;
      overcurrent_trip <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      phase <= (!pumping || phase_wrap) ? 9'h000 : phase + 9'h001;
      ss_count <= (state == cathode_supply_pkg::st_soft_start)
        ? ss_count + 32'h1 : 32'h0000_0000;
      pump_drive_output <= next_drive;
      soft_start_active <= (next_state == cathode_supply_pkg::st_soft_start);
      overcurrent_trip <= (next_state == cathode_supply_pkg::st_tripped);
    end
  end

  // ==========================================================
  // Analog loop settings
  // ==========================================================
  cathode_supply_pkg::regulator_cfg_t next_cfg;
  always_comb begin
    next_cfg.fixed_voltage =
      (mode == cathode_supply_pkg::manual_voltage_mode);
    next_cfg.current_loop =
      (mode != cathode_supply_pkg::manual_voltage_mode);
    next_cfg.clamp_enable =
      (mode == cathode_supply_pkg::clamped_current_mode);
    // Higher code means a less negative cathode level
    next_cfg.voltage_target = cathode_manual_level;
    next_cfg.max_pixel_voltage = max_pixel_voltage;
    next_cfg.reference_factor = next_factor;
    // Dimming is forced to full scale outside the fixed-current mode
    next_cfg.dimming = (mode == cathode_supply_pkg::fixed_current_mode)
      ? luminance_dimming[6:0] : 7'h64;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regulator_cfg <= '0;
    end else if (clk_en) begin
      regulator_cfg <= next_cfg;
    end
  end

endmodule

// ===== cathode_supply_regulator_ctl_sva.sv
/*
  Checker for the cathode-supply converter control block.
  Assumes it is bound to the top module and sees only its ports.
*/
// ==========================================
// Checker
module cathode_supply_regulator_ctl_sva #(
  parameter int SS_UNIT_CYCLES = 10
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic converter_enable,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic pump_drive_output,
  input wire logic soft_start_active,
  input wire logic overcurrent_trip,
  input wire cathode_supply_pkg::regulator_cfg_t regulator_cfg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [31:0] ss_len;
  // Soft start may never outlast the longest duration code
  always_ff @(posedge mclk) begin
    if (sys_rst || !soft_start_active) ss_len <= '0;
    else ss_len <= ss_len + 32'd1;
  end
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not OKAY");
  property p_rd_zero;
    hrdata[31:8] == 24'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("high read bits set");
  property p_trip_quiet;
    overcurrent_trip |-> !pump_drive_output;
  endproperty
  a_trip_quiet: assert property (p_trip_quiet) else $error("pump while tripped");
  property p_trip_hold;
    overcurrent_trip && converter_enable |=> overcurrent_trip;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip not latched");
  property p_dim;
    regulator_cfg.fixed_voltage || regulator_cfg.clamp_enable
      |-> regulator_cfg.dimming == 7'h64;
  endproperty
  a_dim: assert property (p_dim) else $error("dimming outside mode 00");
  property p_excl;
    !(regulator_cfg.fixed_voltage && regulator_cfg.clamp_enable);
  endproperty
  a_excl: assert property (p_excl) else $error("two modes at once");
  property p_factor;
    regulator_cfg.reference_factor <= 9'd239;
  endproperty
  a_factor: assert property (p_factor) else $error("factor too large");
  property p_off;
    !converter_enable ##1 !converter_enable
      |-> !pump_drive_output && !soft_start_active;
  endproperty
  a_off: assert property (p_off) else $error("pump while disabled");
  property p_ss_len;
    ss_len <= SS_UNIT_CYCLES * 8;
  endproperty
  a_ss_len: assert property (p_ss_len) else $error("soft start too long");
  c_trip: cover property ($rose(overcurrent_trip));
  c_ss: cover property ($fell(soft_start_active));
  c_clamp: cover property (regulator_cfg.clamp_enable);
endmodule
bind cathode_supply_regulator_ctl cathode_supply_regulator_ctl_sva #(
  .SS_UNIT_CYCLES(SS_UNIT_CYCLES)
) sva_inst (.mclk, .sys_rst, .converter_enable, .hrdata, .hreadyout,
  .hresp, .pump_drive_output, .soft_start_active, .overcurrent_trip,
  .regulator_cfg);

// ===== cathode_pump_load.sv
/*
  External charge-pump components: a load that can be shorted.
  Assumes the bench commands the short; it is sensed only while pumped.
*/
// ==========================================
// Load model
module cathode_pump_load (
  input wire logic mclk,
  input wire logic pump_drive_output,
  input wire logic short_cmd,
  output logic overcurrent_detect
);
  initial overcurrent_detect = 1'b0;
  // A short draws current only while the pump actually switches
  always @(posedge mclk) overcurrent_detect <= short_cmd && pump_drive_output;
endmodule

// ===== tb_cathode_supply_regulator_ctl.sv
/*
  Testbench for the cathode-supply converter control block.
  Assumes a zero-wait AHB-Lite slave and a shortened soft-start unit.
*/
module tb_cathode_supply_regulator_ctl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SS = 10;
  logic mclk, sys_rst, hsel, hwrite, conv_en, short_cmd, pump, ssa, trip;
  logic hreadyout, hresp, oc;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  cathode_supply_pkg::regulator_cfg_t cfg;
  int fail_count, num_checks, cycles, n;
  cathode_supply_regulator_ctl #(.SS_UNIT_CYCLES(SS))
  cathode_supply_regulator_ctl_inst (.mclk(mclk), .sys_rst(sys_rst),
    .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .converter_enable(conv_en), .overcurrent_detect(oc),
    .pump_drive_output(pump), .soft_start_active(ssa),
    .overcurrent_trip(trip), .regulator_cfg(cfg));
  cathode_pump_load cathode_pump_load_inst (.mclk(mclk),
    .pump_drive_output(pump), .short_cmd(short_cmd),
    .overcurrent_detect(oc));
  // ==========================================
  // Helpers
  task print_verdict();
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task enable(input logic v);
    @(posedge mclk);
    conv_en <= v;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  // ==========================================
  // Scenarios
  task s_regs();
    logic [7:0] rst_v[6] = '{8'h04, 8'h3D, 8'h0D, 8'h51, 8'h00, 8'h01};
    logic [7:0] wr_v[6] = '{8'hFF, 8'hEF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0] rb_v[6] = '{8'h0F, 8'hEF, 8'hFF, 8'hFF, 8'hFF, 8'h7F};
    for (int i = 0; i < 6; i++) begin
      bus(0, 8'h38 + 8'(4 * i), 8'h00);
      chk(rd === {24'h0, rst_v[i]}, "reset value");
      bus(1, 8'h38 + 8'(4 * i), wr_v[i]);
      bus(0, 8'h38 + 8'(4 * i), 8'h00);
      chk(rd === {24'h0, rb_v[i]}, "read back");
    end
    bus(1, 8'h50, 8'hFF);
    bus(0, 8'h50, 8'h00);
    chk(rd === 32'h0, "unmapped read");
  endtask
  task s_cfg();
    bus(1, 8'h48, 8'hE5);
    bus(1, 8'h4C, 8'h32);
    bus(1, 8'h40, 8'h4D);
    bus(1, 8'h44, 8'h80);
    for (int m = 0; m < 4; m++) begin
      bus(1, 8'h38, 8'h04 | 8'(m));
      repeat (2) @(posedge mclk);
      chk(cfg.dimming === ((m == 0 || m == 3) ? 7'h32 : 7'h64), "dim");
      chk(cfg.reference_factor === 9'd213, "factor");
      chk(cfg.max_pixel_voltage === 8'h4D, "max voltage");
      chk(m == 0 || m == 3 || cfg.voltage_target === 8'h80, "level");
      chk(cfg.fixed_voltage === (m == 2), "fixed mode");
      chk(cfg.current_loop === (m != 2), "current loop");
      chk(cfg.clamp_enable === (m == 1), "clamp mode");
    end
    bus(1, 8'h48, 8'h3F);
    repeat (2) @(posedge mclk);
    chk(cfg.reference_factor === 9'd47, "coarse step");
  endtask
  task s_pump();
    logic [7:0] ctl[7] = '{8'hBC, 8'hB4, 8'hB8, 8'hBC, 8'h80, 8'hE0, 8'h98};
    int hi[7] = '{200, 100, 50, 31, 50, 350, 25};
    int lo[7] = '{200, 100, 50, 31, 350, 50, 75};
    int h, l;
    ctl[0] = 8'hB0;
    bus(1, 8'h38, 8'h00);
    for (int i = 0; i < 7; i++) begin
      bus(1, 8'h3C, ctl[i]);
      enable(1);
      h = 0;
      l = 0;
      while (pump === 1'b1) @(negedge mclk);
      while (pump !== 1'b1) @(negedge mclk);
      while (pump === 1'b1) begin h++; @(negedge mclk); end
      while (pump === 1'b0) begin l++; @(negedge mclk); end
      chk(h == hi[i] && l == lo[i], "pump shape");
      enable(0);
    end
  endtask
  task s_soft();
    for (int c = 0; c < 5; c++) begin
      bus(1, 8'h3C, (c == 4) ? 8'hBD : 8'h3C | 8'(c));
      enable(1);
      n = 0;
      while (ssa === 1'b1) begin n++; @(negedge mclk); end
      chk(n == ((c == 4) ? 0 : SS << c), "soft start length");
      enable(0);
    end
  endtask
  task s_trip();
    for (int s = 0; s < 4; s++) begin
      bus(1, 8'h38, 8'(s << 2));
      bus(1, 8'h3C, 8'hBC);
      enable(1);
      repeat (20) @(posedge mclk);
      short_cmd <= 1'b1;
      repeat (80) @(posedge mclk);
      short_cmd <= 1'b0;
      repeat (3) @(negedge mclk);
      chk(trip === (s == 1 || s == 3), "trip latch");
      chk(s == 0 || s == 2 || pump === 1'b0, "pump stopped");
      enable(0);
      @(negedge mclk);
      chk(trip === 1'b0, "trip cleared");
    end
  endtask
  // ==========================================
  // Sequence and timeout
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    {hsel, hwrite, conv_en, short_cmd, haddr, htrans, hwdata} = '0;
    sys_rst = 1;
    repeat (6) @(posedge mclk);
    sys_rst <= 0;
    s_regs();
    s_cfg();
    s_pump();
    s_soft();
    s_trip();
    print_verdict();
  end
endmodule
